/* File: verification/sdm_pulse_source.sv */
// Upstream positioning controller model that drives the step link pins.
`timescale 1ns/1ps

module sdm_pulse_source
(
  output logic step_line,
  output logic sense_line
);
  logic lclk;
  logic run;
  logic last_ccw;

  // Lines idle low; the link clock rests between bursts.
  initial
  begin
    step_line  = 1'b0;
    sense_line = 1'b0;
    run        = 1'b0;
    lclk       = 1'b0;
    last_ccw   = 1'b0;
  end

  // A 48 ns link clock that toggles only inside a burst.
  always #24 lclk = run ? ~lclk : 1'b0;

  // Sends n pulses; dual selects which line carries them for each sense.
  task automatic send(input int n, input bit ccw, input bit dual);
    int i;
    if (ccw != last_ccw)
    begin
      last_ccw   = ccw;
      sense_line = dual ? 1'b0 : ccw;
      #35000;
    end
    run = 1'b1;
    for (i = 0; i < n; i++)
    begin
      @(posedge lclk);
      if (dual && ccw) sense_line = 1'b1;
      else step_line = 1'b1;
      repeat (5) @(posedge lclk);
      step_line  = 1'b0;
      sense_line = dual ? 1'b0 : ccw;
      repeat (16) @(posedge lclk);
    end
    run = 1'b0;
  endtask
endmodule // sdm_pulse_source

/* File: verification/sdm_step_dio_checker.sv */
// Port-level assertions for the step/direction block.
`timescale 1ns/1ps
`include "sdm_regs.vh"

module sdm_checker
#(
  parameter W = 32
)
(
  input wire         clk,
  input wire         rst,
  input wire [3:0]   reg_addr,
  input wire [31:0]  reg_wdata,
  input wire         reg_wr,
  input wire         reg_rd,
  input wire [31:0]  reg_rdata,
  input wire         step_pulse_pin_in,
  input wire         rotation_sense_pin_in,
  input wire [3:0]   pin_out,
  input wire [3:0]   pin_oe,
  input wire [3:0]   pin_pull_up,
  input wire [3:0]   pin_pull_down,
  input wire         step_mode_active,
  input wire [W-1:0] demand_pos_q,
  input wire         limit_hit_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  reg [7:0] mode_q;
  reg [3:0] age_q;
  reg       stp_q;
  reg       sns_q;
  wire      pos_wr = reg_wr && reg_addr == `SDM_ADDR_POS;

  // Shadow mode byte, and cycles since the last rise on either link pin.
  always @(posedge clk)
  begin
    stp_q <= step_pulse_pin_in;
    sns_q <= rotation_sense_pin_in;
    if (rst)
      mode_q <= 8'h00;
    else if (reg_wr && reg_addr == `SDM_ADDR_MODE)
      mode_q <= reg_wdata[7:0];
    if ((step_pulse_pin_in && !stp_q) || (rotation_sense_pin_in && !sns_q))
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_mode_decode: assert property (step_mode_active == (mode_q == 8'hFF))
    else $error("step mode flag disagrees with mode byte");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_rd: assert property (reg_rd && reg_addr >= 4'hE |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_oe_mask: assert property (reg_wr && reg_addr == `SDM_ADDR_DIR_MASK
    |-> ##2 pin_oe == $past(reg_wdata[3:0], 2)) else $error("output enable not from mask");
  chk_pull_split: assert property ((pin_pull_up | pin_pull_down) == ~pin_oe
    && (pin_pull_up & pin_pull_down) == 4'h0) else $error("pull on output pin");
  chk_pull_mask: assert property (reg_wr && reg_addr == `SDM_ADDR_PULL_MASK
    |-> ##2 pin_pull_up == ($past(reg_wdata[3:0], 2) & ~pin_oe)) else $error("pull-up wrong");
  chk_out_level: assert property (reg_wr && reg_addr == `SDM_ADDR_OUT_WORD
    |-> ##2 pin_out == $past(reg_wdata[19:16], 2)) else $error("pin drive level wrong");
  chk_reset_vals: assert property ($fell(rst) |-> pin_oe == 4'h0
    && pin_pull_down == 4'hF && demand_pos_q == '0) else $error("bad reset state");
  chk_pos_cause: assert property ($changed(demand_pos_q) && !$past(pos_wr)
    |-> $past(step_mode_active) && age_q inside {[1:8]}) else $error("stray move");
  chk_limit_mode: assert property (limit_hit_q |-> $past(step_mode_active))
    else $error("limit flag outside step mode");

  cov_step: cover property ($changed(demand_pos_q) && !$past(pos_wr));
  cov_unmapped: cover property (reg_rd && reg_addr >= 4'hE);
  cov_limit: cover property ($rose(limit_hit_q));
endmodule // sdm_checker

/* File: verification/testbench.sv */
// Self-checking bench for the step/direction block and its pin map.
`timescale 1ns/1ps
`include "sdm_regs.vh"

module testbench;
  localparam W = 32;
  reg          clk;
  reg          rst;
  reg  [3:0]   reg_addr;
  reg  [31:0]  reg_wdata;
  reg          reg_wr;
  reg          reg_rd;
  reg          closed_loop;
  reg  [5:0]   ext;
  reg  [31:0]  d;
  wire [31:0]  reg_rdata;
  wire [3:0]   pin_out;
  wire [3:0]   pin_oe;
  wire [3:0]   pin_pull_up;
  wire [3:0]   pin_pull_down;
  wire         step_mode_active;
  wire [W-1:0] demand_pos_q;
  wire         limit_hit_q;
  wire         step_line;
  wire         sense_line;
  // A driven pin shows the block's own level, otherwise the outside source.
  wire [3:0]   src = {ext[3], sense_line, step_line, ext[0]};
  wire [3:0]   pin = (pin_oe & pin_out) | (~pin_oe & src);
  int          err_count;
  int          n_checks;

  sdm_step_dio #(.W(W), .MS_CYCLES(10)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flex_pin_one_in(pin[0]), .step_pulse_pin_in(pin[1]),
    .rotation_sense_pin_in(pin[2]), .flex_pin_four_in(pin[3]),
    .fixed_input_five(ext[4]), .fixed_input_six(ext[5]),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .closed_loop(closed_loop),
    .step_mode_active(step_mode_active), .demand_pos_q(demand_pos_q),
    .limit_hit_q(limit_hit_q));

  sdm_pulse_source pg (.step_line(step_line), .sense_line(sense_line));

  // 200 MHz clock.
  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // Bus and checking tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data appear the cycle after the strobe and hold until the next read; sample there.
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic summarize;
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    bus_rd(`SDM_ADDR_NUMER);
    chk("numerator", d, 32'h0000_0080);
    bus_rd(`SDM_ADDR_DENOM);
    chk("denominator", d, 32'h0000_0001);
    bus_rd(`SDM_ADDR_DIR_MASK);
    chk("dir mask rst", d, 32'h0000_0000);
    bus_rd(4'hE);
    chk("unmapped", d, 32'h0000_0000);
    chk("pull down rst", {28'h0, pin_pull_down}, 32'h0000_000F);
  endtask

  task automatic t_mode;
    bus_wr(`SDM_ADDR_MODE, 32'h0000_00FE);
    pg.send(2, 1'b0, 1'b0);
    chk("pos idle", demand_pos_q, 32'h0000_0000);
    bus_wr(`SDM_ADDR_MODE, 32'h0000_00FF);
    #1 chk("mode on", {31'h0, step_mode_active}, 32'h0000_0001);
  endtask

  task automatic t_tr;
    pg.send(3, 1'b0, 1'b0);
    chk("pos cw", demand_pos_q, 32'h0000_0180);
    pg.send(1, 1'b1, 1'b0);
    bus_rd(`SDM_ADDR_POS);
    chk("pos ccw", d, 32'h0000_0100);
  endtask

  // The scaler takes some tens of cycles; poll its busy bit with a bound.
  task automatic t_scale;
    int k;
    bus_wr(`SDM_ADDR_NUMER, 32'h0000_0200);
    bus_wr(`SDM_ADDR_DENOM, 32'h0000_0002);
    for (k = 0; k < 64; k++)
    begin
      bus_rd(`SDM_ADDR_STATUS);
      if (d[8] === 1'b0) break;
    end
    if (k == 64)
    begin
      err_count++;
      summarize();
    end
    bus_wr(`SDM_ADDR_POS, 32'h0000_0000);
    pg.send(2, 1'b0, 1'b0);
    chk("pos scaled", demand_pos_q, 32'h0000_0200);
  endtask

  task automatic t_dual;
    bus_wr(`SDM_ADDR_SUBTYPE, 32'h0000_0001);
    pg.send(1, 1'b1, 1'b1);
    chk("dual ccw", demand_pos_q, 32'h0000_0100);
    pg.send(2, 1'b0, 1'b1);
    chk("dual cw", demand_pos_q, 32'h0000_0300);
    bus_wr(`SDM_ADDR_SUBTYPE, 32'h0000_0000);
  endtask

  task automatic t_dio;
    ext <= 6'h11;
    bus_wr(`SDM_ADDR_DIR_MASK, 32'h0000_0036);
    bus_wr(`SDM_ADDR_PULL_MASK, 32'h0000_000F);
    bus_wr(`SDM_ADDR_OUT_WORD, 32'h000F_0000);
    bus_rd(`SDM_ADDR_DIR_MASK);
    chk("dir mask", d, 32'h0000_0006);
    chk("oe", {28'h0, pin_oe}, 32'h0000_0006);
    chk("pulls", {24'h0, pin_pull_up, pin_pull_down}, 32'h0000_0090);
    repeat (4) @(posedge clk);
    bus_rd(`SDM_ADDR_IN_WORD);
    chk("levels", d & 32'h003F_0000, 32'h0017_0000);
    bus_wr(`SDM_ADDR_SPECIAL, 32'h0000_0001);
    bus_rd(`SDM_ADDR_IN_WORD);
    chk("neg limit", d & 32'h0001_0001, 32'h0001_0001);
    chk("limit hit", {31'h0, limit_hit_q}, 32'h0000_0001);
    ext <= 6'h00;
    bus_wr(`SDM_ADDR_SPECIAL, 32'h0000_0000);
    bus_wr(`SDM_ADDR_DIR_MASK, 32'h0000_0000);
  endtask

  // Window 16, timeout 2 ms of 10 cycles each; position sits far outside.
  task automatic t_follow;
    closed_loop <= 1'b1;
    bus_wr(`SDM_ADDR_FE_WIN, 32'h0000_0010);
    bus_wr(`SDM_ADDR_FE_TMO, 32'h0000_0002);
    repeat (60) @(posedge clk);
    bus_rd(`SDM_ADDR_STATUS);
    chk("follow set", d & 32'h0000_2080, 32'h0000_2080);
    bus_wr(`SDM_ADDR_ACT_POS, 32'h0000_0300);
    bus_rd(`SDM_ADDR_STATUS);
    chk("follow clear", d & 32'h0000_2000, 32'h0000_0000);
  endtask

  // Reset for five cycles, then run every scenario in turn.
  initial
  begin
    clk         = 1'b0;
    rst         = 1'b1;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    closed_loop = 1'b0;
    ext         = 6'h00;
    err_count   = 0;
    n_checks    = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode();
    t_tr();
    t_scale();
    t_dual();
    t_dio();
    t_follow();
    summarize();
  end
endmodule // testbench

bind sdm_step_dio sdm_checker #(.W(W)) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .step_pulse_pin_in(step_pulse_pin_in), .rotation_sense_pin_in(rotation_sense_pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
  .pin_pull_down(pin_pull_down), .step_mode_active(step_mode_active),
  .demand_pos_q(demand_pos_q), .limit_hit_q(limit_hit_q));

/* File: verilog/sdm_regs.vh */
// Register offsets, field positions, reset values and timing counts of the step/direction block.
`ifndef SDM_REGS_VH
`define SDM_REGS_VH

// ---------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ---------------------------------------------------------------
`define SDM_ADDR_MODE       4'h0
`define SDM_ADDR_SUBTYPE    4'h1
`define SDM_ADDR_NUMER      4'h2
`define SDM_ADDR_DENOM      4'h3
`define SDM_ADDR_DIR_MASK   4'h4
`define SDM_ADDR_PULL_MASK  4'h5
`define SDM_ADDR_OUT_WORD   4'h6
`define SDM_ADDR_IN_WORD    4'h7
`define SDM_ADDR_POS        4'h8
`define SDM_ADDR_STATUS     4'h9
`define SDM_ADDR_FE_WIN     4'hA
`define SDM_ADDR_FE_TMO     4'hB
`define SDM_ADDR_ACT_POS    4'hC
`define SDM_ADDR_SPECIAL    4'hD

// ---------------------------------------------------------------
// Values, fields and reset values
// ---------------------------------------------------------------
`define SDM_MODE_STEP       8'hFF
`define SDM_SUB_PULSE_SENSE 8'h00
`define SDM_SUB_DUAL_LINE   8'h01
`define SDM_NUMER_RST       32'h0000_0080
`define SDM_DENOM_RST       32'h0000_0001
`define SDM_FULL_STEP       32'h0000_0200
`define SDM_STEPS_PER_PP    4
`define SDM_STAT_FOLLOW_BIT 13
`define SDM_STAT_LIMIT_BIT  11
`define SDM_LEVEL_BASE      16
`define SDM_FE_WIN_RST      32'h0000_0800
`define SDM_FE_TMO_RST      16'h0064
`define SDM_MS_NS           1000000
`define SDM_CLK_NS          5
`define SDM_MS_CYCLES       (`SDM_MS_NS / `SDM_CLK_NS)

`endif

/* File: verilog/sdm_scale.v */
// Step increment scaler: numerator divided by denominator, by serial division.
`timescale 1ns/1ps

module sdm_scale
#(
  parameter W = 32
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire         start,
  input  wire [W-1:0] numer,
  input  wire [W-1:0] denom,
  output reg  [W-1:0] quot_q,
  output wire         busy
);

  reg  [W-1:0] rem_q;
  reg  [W-1:0] num_q;
  reg  [W-1:0] den_q;
  reg  [5:0]   cnt_q;
  wire [W:0]   trial;

  assign trial = {rem_q, num_q[W-1]} - {1'b0, den_q};
  assign busy  = (cnt_q != 6'd0);

  // ---------------------------------------------------------------
  // Restoring divider
  // ---------------------------------------------------------------
  // Division takes W cycles; settings change rarely, so area wins over speed.
  // A zero denominator yields all ones, so each step adds the all-ones increment and the position wraps rather than stops.
  always @(posedge clk)
  begin
    if (rst)
    begin
      quot_q <= {{(W-8){1'b0}}, 8'h80};
      rem_q  <= {W{1'b0}};
      num_q  <= {W{1'b0}};
      den_q  <= {W{1'b0}};
      cnt_q  <= 6'd0;
    end
    else if (start)
    begin
      rem_q  <= {W{1'b0}};
      num_q  <= numer;
      den_q  <= denom;
      cnt_q  <= W[5:0];
    end
    else if (busy)
    begin
      if (!trial[W])
        rem_q <= trial[W-1:0];
      else
        rem_q <= {rem_q[W-2:0], num_q[W-1]};
      num_q <= {num_q[W-2:0], ~trial[W]};
      cnt_q <= cnt_q - 6'd1;
      if (cnt_q == 6'd1)
        quot_q <= {num_q[W-2:0], ~trial[W]};
    end
  end

endmodule // sdm_scale

/* File: verilog/sdm_step_dio.v */
// Step/direction motion input with six-pin digital I/O configuration and bit map.
//
// Function
// [R1] Step-pulse mode active only when mode selector holds FF hex.
// [R2] Each step pulse advances position one scaled step in the chosen sense.
// [R3] Controller keeps pulse rate at most 1 MHz, active phase at least 200 ns.
// [R4] Increment per pulse is numerator setting divided by denominator setting.
// [R5] Increment defaults to 128 (128/1), a quarter step; 512 is full step.
// [R6] Brushless motors handled as steppers, four full steps per pole pair.
// [R7] Controller waits at least 35 us after direction change before next pulse.
// [R8] Closed loop: status bit 13 set when following error exceeds window past timeout.
// [R9] Subtype 0: step input gives pulses, direction input level picks sense.
// [R10] Subtype 1: the input carrying the pulses decides clockwise or counter-clockwise.
// [R11] Limit switch monitoring stays active during step-pulse mode.
// [R12] Six I/O pins; pins one to four configurable, five and six inputs.
// [R13] Direction mask bits 0..3 map pins one..four; 1 means output.
// [R14] Pull mask bits 0..3 choose pull-up (1) or pull-down, only for inputs.
// [R15] Special-function bits in 0..15, raw level of pin n at bit 15+n.
// [R16] Input one's negative limit shows in bit 0 when enabled; bit 16 always.
// [R17] Pins one..four readable at 16..19 as outputs; five at 20, six at 21.
// [R18] In step-pulse mode input two is step, input three is direction.
// [R19] Step/direction synchronised; each rising edge counted once into signed position.
// [R20] Writing pins five and six as outputs is ignored.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "sdm_regs.vh"

module sdm_step_dio
#(
  parameter W         = 32,
  parameter MS_CYCLES = `SDM_MS_CYCLES
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire [3:0]   reg_addr,
  input  wire [31:0]  reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [31:0]  reg_rdata,
  input  wire         flex_pin_one_in,
  input  wire         step_pulse_pin_in,
  input  wire         rotation_sense_pin_in,
  input  wire         flex_pin_four_in,
  input  wire         fixed_input_five,
  input  wire         fixed_input_six,
  output reg  [3:0]   pin_out,
  output reg  [3:0]   pin_oe,
  output reg  [3:0]   pin_pull_up,
  output reg  [3:0]   pin_pull_down,
  input  wire         closed_loop,
  output wire         step_mode_active,
  output reg  [W-1:0] demand_pos_q,
  output reg          limit_hit_q
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg  [7:0]   mode_q;
  reg  [7:0]   subtype_q;
  reg  [W-1:0] numer_q;
  reg  [W-1:0] denom_q;
  reg  [15:0]  pin_direction_mask_q;
  reg  [15:0]  pin_pull_select_mask_q;
  reg  [3:0]   out_level_q;
  reg  [2:0]   special_en_q;
  reg  [W-1:0] fe_window_q;
  reg  [15:0]  fe_timeout_q;
  reg  [W-1:0] act_pos_q;
  reg          follow_err_q;
  reg          scale_start_q;

  wire [5:0]   lvl;
  wire [5:0]   rise;
  wire [W-1:0] step_inc;
  wire         scale_busy;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Each pin passes two flops before use; edges come from the settled copy.
  sdm_sync_edge u_s1 (.clk(clk), .rst(rst), .pin_in(flex_pin_one_in),
                      .level(lvl[0]), .rise(rise[0])); // [R19]
  sdm_sync_edge u_s2 (.clk(clk), .rst(rst), .pin_in(step_pulse_pin_in),
                      .level(lvl[1]), .rise(rise[1])); // [R19]
  sdm_sync_edge u_s3 (.clk(clk), .rst(rst), .pin_in(rotation_sense_pin_in),
                      .level(lvl[2]), .rise(rise[2])); // [R19]
  sdm_sync_edge u_s4 (.clk(clk), .rst(rst), .pin_in(flex_pin_four_in),
                      .level(lvl[3]), .rise(rise[3]));
  sdm_sync_edge u_s5 (.clk(clk), .rst(rst), .pin_in(fixed_input_five),
                      .level(lvl[4]), .rise(rise[4]));
  sdm_sync_edge u_s6 (.clk(clk), .rst(rst), .pin_in(fixed_input_six),
                      .level(lvl[5]), .rise(rise[5]));

  // ---------------------------------------------------------------
  // Step scaling
  // ---------------------------------------------------------------
  sdm_scale #(.W(W)) u_scale
  (
    .clk    (clk),
    .rst    (rst),
    .start  (scale_start_q),
    .numer  (numer_q),
    .denom  (denom_q),
    .quot_q (step_inc),
    .busy   (scale_busy)
  ); // [R4]

  assign step_mode_active = (mode_q == `SDM_MODE_STEP); // [R1]

  // Absolute difference, used for the following error check.
  function [W-1:0] abs_diff;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      abs_diff = ($signed(a) > $signed(b)) ? (a - b) : (b - a);
    end
  endfunction

  // ---------------------------------------------------------------
  // Step decoding
  // ---------------------------------------------------------------
  // Input two carries pulses, input three direction or the second pulse line.
  reg fwd_step;
  reg rev_step;
  always @*
  begin
    fwd_step = 1'b0;
    rev_step = 1'b0;
    if (step_mode_active && pin_direction_mask_q[1] == 1'b0) // [R18]
    begin
      case (subtype_q)
        `SDM_SUB_DUAL_LINE:
        begin
          fwd_step = rise[1]; // [R10]
          rev_step = rise[2] & ~pin_direction_mask_q[2]; // [R10]
        end
        default:
        begin
          fwd_step = rise[1] & ~lvl[2]; // [R9]
          rev_step = rise[1] & lvl[2];  // [R9]
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Position accumulator and limit monitoring
  // ---------------------------------------------------------------
  // A step into an active limit switch is held off; steps away still count.
  // Direction-to-step setup time and pulse rate are the controller's burden.
  // The 1 MHz ceiling leaves 200 clocks per pulse, far above the edge detector.
  wire neg_lim = special_en_q[0] & lvl[0];
  wire pos_lim = special_en_q[1] & lvl[3];
  always @(posedge clk)
  begin
    if (rst)
    begin
      demand_pos_q <= {W{1'b0}};
      limit_hit_q  <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `SDM_ADDR_POS)
        demand_pos_q <= reg_wdata[W-1:0];
      else if (fwd_step && !pos_lim) // [R3] [R7]
        demand_pos_q <= demand_pos_q + step_inc; // [R2] [R19]
      else if (rev_step && !neg_lim)
        demand_pos_q <= demand_pos_q - step_inc; // [R2] [R19]
      limit_hit_q <= step_mode_active & (neg_lim | pos_lim); // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Following error monitor
  // ---------------------------------------------------------------
  // Millisecond tick divides the clock; the error must persist past timeout.
  reg [31:0] ms_cnt_q;
  reg [15:0] fe_ms_q;
  wire       ms_tick = (ms_cnt_q == MS_CYCLES - 1);
  wire       fe_out  = abs_diff(demand_pos_q, act_pos_q) > fe_window_q;
  always @(posedge clk)
  begin
    if (rst)
    begin
      ms_cnt_q     <= 32'h0000_0000;
      fe_ms_q      <= 16'h0000;
      follow_err_q <= 1'b0;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (!(closed_loop && step_mode_active && fe_out))
      begin
        fe_ms_q      <= 16'h0000;
        follow_err_q <= 1'b0;
      end
      else if (ms_tick)
      begin
        if (fe_ms_q >= fe_timeout_q)
          follow_err_q <= 1'b1; // [R8]
        else
          fe_ms_q <= fe_ms_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      mode_q                 <= 8'h00;
      subtype_q              <= `SDM_SUB_PULSE_SENSE; // [R9]
      numer_q                <= `SDM_NUMER_RST; // [R5]
      denom_q                <= `SDM_DENOM_RST; // [R5]
      pin_direction_mask_q   <= 16'h0000; // [R13]
      pin_pull_select_mask_q <= 16'h0000; // [R14]
      out_level_q            <= 4'h0;
      special_en_q           <= 3'h0;
      fe_window_q            <= `SDM_FE_WIN_RST;
      fe_timeout_q           <= `SDM_FE_TMO_RST;
      act_pos_q              <= {W{1'b0}};
      scale_start_q          <= 1'b0;
    end
    else
    begin
      scale_start_q <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          `SDM_ADDR_MODE:      mode_q <= reg_wdata[7:0];
          `SDM_ADDR_SUBTYPE:   subtype_q <= reg_wdata[7:0];
          `SDM_ADDR_NUMER:
          begin
            numer_q       <= reg_wdata[W-1:0];
            scale_start_q <= 1'b1;
          end
          `SDM_ADDR_DENOM:
          begin
            denom_q       <= reg_wdata[W-1:0];
            scale_start_q <= 1'b1;
          end
          `SDM_ADDR_DIR_MASK:  pin_direction_mask_q <= {12'h000, reg_wdata[3:0]}; // [R20]
          `SDM_ADDR_PULL_MASK: pin_pull_select_mask_q <= {12'h000, reg_wdata[3:0]};
          `SDM_ADDR_OUT_WORD:  out_level_q <= reg_wdata[19:16];
          `SDM_ADDR_FE_WIN:    fe_window_q <= reg_wdata[W-1:0];
          `SDM_ADDR_FE_TMO:    fe_timeout_q <= reg_wdata[15:0];
          `SDM_ADDR_ACT_POS:   act_pos_q <= reg_wdata[W-1:0];
          `SDM_ADDR_SPECIAL:   special_en_q <= reg_wdata[2:0];
          default:             mode_q <= mode_q;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Pulls apply only to input pins; an output pin gets neither pull.
  always @(posedge clk)
  begin
    if (rst)
    begin
      pin_out       <= 4'h0;
      pin_oe        <= 4'h0;
      pin_pull_up   <= 4'h0;
      pin_pull_down <= 4'hF;
    end
    else
    begin
      pin_out       <= out_level_q;
      pin_oe        <= pin_direction_mask_q[3:0]; // [R12] [R13]
      pin_pull_up   <= ~pin_direction_mask_q[3:0] & pin_pull_select_mask_q[3:0]; // [R14]
      pin_pull_down <= ~pin_direction_mask_q[3:0] & ~pin_pull_select_mask_q[3:0]; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Input word and status
  // ---------------------------------------------------------------
  // Levels read back even for output pins, through the same synchroniser.
  wire [31:0] in_word = {10'h000, lvl, 13'h0000, special_en_q[2] & lvl[2],
                         pos_lim, neg_lim}; // [R15] [R16] [R17]
  wire [31:0] status  = {18'h00000, follow_err_q, 1'b0, limit_hit_q,
                         2'b00, scale_busy, step_mode_active, 7'h00};
  // The level bits sit at 16 + pin index, fixed whatever the direction.
  wire [31:0] out_word = {12'h000, out_level_q, 16'h0000};

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Data appear the cycle after the read strobe; unmapped reads give zero.
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SDM_ADDR_MODE:      reg_rdata <= {24'h000000, mode_q};
        `SDM_ADDR_SUBTYPE:   reg_rdata <= {24'h000000, subtype_q};
        `SDM_ADDR_NUMER:     reg_rdata <= numer_q;
        `SDM_ADDR_DENOM:     reg_rdata <= denom_q;
        `SDM_ADDR_DIR_MASK:  reg_rdata <= {16'h0000, pin_direction_mask_q};
        `SDM_ADDR_PULL_MASK: reg_rdata <= {16'h0000, pin_pull_select_mask_q};
        `SDM_ADDR_OUT_WORD:  reg_rdata <= out_word;
        `SDM_ADDR_IN_WORD:   reg_rdata <= in_word;
        `SDM_ADDR_POS:       reg_rdata <= demand_pos_q;
        `SDM_ADDR_STATUS:    reg_rdata <= status; // [R8]
        `SDM_ADDR_FE_WIN:    reg_rdata <= fe_window_q;
        `SDM_ADDR_FE_TMO:    reg_rdata <= {16'h0000, fe_timeout_q};
        `SDM_ADDR_ACT_POS:   reg_rdata <= act_pos_q;
        `SDM_ADDR_SPECIAL:   reg_rdata <= {29'h0000_0000, special_en_q};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Stepper treatment: position units of 512 per full step, four per pole pair.
  // [R6] No separate logic is needed; the scaler works in the same step units.

endmodule // sdm_step_dio

/* File: verilog/sdm_sync_edge.v */
// Two-stage synchroniser with rising-edge detect for one pin input.
`timescale 1ns/1ps

module sdm_sync_edge
(
  input  wire clk,
  input  wire rst,
  input  wire pin_in,
  output wire level,
  output wire rise
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // ---------------------------------------------------------------
  // Synchroniser
  // ---------------------------------------------------------------
  // The first stage feeds only the second stage to keep metastability contained.
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;

endmodule // sdm_sync_edge
